// [include/mgmt_pkg.sv]
`default_nettype none
package mgmt_pkg;
  // clock and tick figures
  localparam int CLK_MHZ = 200;
  localparam int US_CYCLES = CLK_MHZ;
  localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
  // shortest host reset pulse, in us, and its cycle count (rounded up)
  localparam int RESET_MIN_US = 2;
  localparam logic [9:0] RESET_MIN_CYCLES = 10'(RESET_MIN_US * CLK_MHZ);
  // documented upper bounds, kept for the checker side
  localparam int INIT_LIMIT_MS = 2000;
  localparam int LP_ASSERT_LIMIT_US = 100;
  localparam int IRQ_ASSERT_LIMIT_MS = 200;
  localparam int IRQ_RELEASE_LIMIT_US = 500;
  localparam int LOS_ASSERT_LIMIT_MS = 100;
  localparam int MASK_LIMIT_MS = 100;
  localparam int RX_SQUELCH_LIMIT_US = 80;
  localparam int TX_SQUELCH_LIMIT_MS = 400;
  localparam int DISABLE_ASSERT_LIMIT_MS = 100;
  // serial slave address (7-bit form of the 8-bit A0h)
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // lower page byte offsets and bit positions
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam int DNR_BIT = 0;
  localparam int IRQ_BIT = 1;
  localparam logic [7:0] OFS_LOS = 8'h03;
  localparam logic [7:0] OFS_FAULT = 8'h04;
  localparam logic [7:0] OFS_TXDIS = 8'h56;
  localparam logic [7:0] OFS_PWR = 8'h5D;
  localparam int PWR_DOWN_BIT = 1;
  localparam logic [7:0] OFS_MASK_LOS = 8'h64;
  localparam logic [7:0] OFS_MASK_FAULT = 8'h65;
  localparam logic [7:0] OFS_PAGE = 8'h7F;
  // upper page holding squelch and receive-disable controls
  localparam logic [1:0] CTL_PAGE = 2'h3;
  localparam logic [7:0] OFS_SQDIS = 8'hF0;
  localparam logic [7:0] OFS_RXDIS = 8'hF1;
  // upper page store: 4 pages of 128 bytes
  localparam int PAGE_BITS = 2;
  localparam int MEM_AW = PAGE_BITS + 7;
  localparam int MEM_WORDS = 1 << MEM_AW;
  // lane control vector layout
  localparam int LANES = 4;
  localparam int CTRL_W = 22;
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_WR, TW_WR_ACK, TW_RD, TW_RD_ACK
  } tws_state_e;
endpackage
`default_nettype wire

// [design/upper_page_mem.sv]
`default_nettype none
module upper_page_mem
  import mgmt_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [MEM_AW-1:0] waddr, // write address
  input wire logic [7:0] wdata, // write byte
  input wire logic [MEM_AW-1:0] raddr, // read address
  output logic [7:0] rdata_q // registered read byte
);
  logic [7:0] mem [MEM_WORDS];

  // one write port, registered read one cycle after the address
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // upper_page_mem
`default_nettype wire

// [design/module_mgmt.sv]
// Functional notes
// - become ready within 2000 ms after reset
// - low power request enters level 1 quickly
// - interrupt pin asserts promptly on any condition
// - interrupt releases soon after flag read clears
// - reset pin low over 2 us resets
// - serial bus answers within 2000 ms
// - clear data-not-ready, raise interrupt at init
// - receive loss sets flag and interrupt
// - transmit fault sets flag and interrupt
// - other flagged conditions set flag, interrupt
// - mask bits gate and restore interrupt quickly
// - power-down bit enters and leaves level 1
// - receive squelch follows signal loss, 80 us
// - transmit squelch follows signal loss
// - transmit disable bit turns output off
// - receive disable bit turns output off
// - squelch-disable bits turn squelching off
// - one address, lower page, selectable upper pages
// - flags low, identity and thresholds upper
// - status flags latch, clear on read
// - deselected module ignores serial bus traffic
// - fault disables channel, disable toggle restores
`default_nettype none
module module_mgmt
  import mgmt_pkg::*;
#(
  parameter int INIT_WAIT_US = 100 // power-up settle time, under 2000 ms
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic lane_clk, // lane-side clock
  input wire logic module_select_n, // pin, low selects module
  input wire logic low_power_request, // pin, high asks low power
  input wire logic module_reset_n, // pin, low resets module
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe, // serial data drive enable
  output logic interrupt_n_out, // interrupt drive value
  output logic interrupt_n_oe, // interrupt drive enable
  input wire logic [LANES-1:0] rx_los_raw, // lane: rx signal lost
  input wire logic [LANES-1:0] tx_los_raw, // lane: tx signal lost
  input wire logic [LANES-1:0] tx_fault_raw, // lane: tx fault
  output logic [LANES-1:0] rx_squelch, // lane: squelch rx output
  output logic [LANES-1:0] tx_squelch, // lane: squelch tx output
  output logic [LANES-1:0] rx_output_on, // lane: rx output enabled
  output logic [LANES-1:0] tx_output_on, // lane: tx output enabled
  output logic low_power_state, // module held at power level 1
  output logic module_ready // module fully functional
);
  localparam logic [20:0] INIT_LAST = 21'(INIT_WAIT_US - 1);

  typedef struct packed {
    logic [4:0] pin_s1; // {rst_n, lpreq, sel_n, sda, scl}
    logic [4:0] pin_s2;
    logic [1:0] pin_p; // previous {sda, scl}
    logic [11:0] lane_s1; // {fault, tx_los, rx_los}
    logic [11:0] lane_s2;
    logic [11:0] lane_p;
    logic [7:0] us_cnt;
    logic [20:0] init_cnt;
    logic ready;
    logic dnr;
    logic init_flag;
    logic [9:0] rst_cnt;
    logic rst_hold;
    logic [7:0] los_flag; // {tx_los, rx_los}
    logic [3:0] fault_flag;
    logic [3:0] fault_state;
    logic [3:0] tx_dis;
    logic pwr_down;
    logic [7:0] mask_los;
    logic [3:0] mask_fault;
    logic [1:0] page;
    logic [7:0] sqdis; // {rx, tx}
    logic [3:0] rx_dis;
    tws_state_e st;
    logic [7:0] shift;
    logic [3:0] bitn;
    logic [7:0] offset;
    logic is_read;
    logic first;
    logic acked;
    logic sda_oe;
    logic irq_oe;
    logic [CTRL_W-1:0] ctrl;
  } core_s;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl_s1;
    logic [CTRL_W-1:0] ctrl_s2;
    logic [11:0] status;
    logic [3:0] rx_sq;
    logic [3:0] tx_sq;
    logic [3:0] rx_on;
    logic [3:0] tx_on;
  } lane_s;

  localparam core_s CORE_RST = '{pin_s1: 5'h1F, pin_s2: 5'h1F,
                                 pin_p: 2'h3, dnr: 1'b1,
                                 st: TW_IDLE, default: '0};

  core_s q, d;
  lane_s lq, ld;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;

  // lower page read decode; unlisted bytes read zero
  function automatic logic [7:0] rd_lower(input core_s s,
                                          input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      OFS_STATUS: begin
        v[DNR_BIT] = s.dnr;
        v[IRQ_BIT] = s.irq_oe;
      end
      OFS_LOS: v = s.los_flag;
      OFS_FAULT: v = {4'h0, s.fault_flag};
      OFS_TXDIS: v = {4'h0, s.tx_dis};
      OFS_PWR: v[PWR_DOWN_BIT] = s.pwr_down;
      OFS_MASK_LOS: v = s.mask_los;
      OFS_MASK_FAULT: v = {4'h0, s.mask_fault};
      OFS_PAGE: v = {6'h00, s.page};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // true when an upper offset hits a control register, not the store
  function automatic logic is_ctl(input logic [1:0] pg,
                                  input logic [7:0] ofs);
    return pg == CTL_PAGE && (ofs == OFS_SQDIS || ofs == OFS_RXDIS);
  endfunction

  upper_page_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr({q.page, q.offset[6:0]}),
    .rdata_q(mem_rdata)
  );

  // core next state: pins, timers, serial slave, flags, controls
  always_comb begin
    logic scl, sda, scl_rise, scl_fall, start, stop, sel_ok;
    logic [7:0] byte_v;
    logic [11:0] rise, lvl;
    logic clr2, clr3, clr4, load, irq, us_tick;
    logic [3:0] txdis_old;
    core_s keep;
    keep = q;
    d = q;
    mem_we = 1'b0;
    mem_waddr = {q.page, q.offset[6:0]};
    mem_wdata = q.shift;
    clr2 = 1'b0;
    clr3 = 1'b0;
    clr4 = 1'b0;
    load = 1'b0;
    byte_v = 8'h00;
    txdis_old = q.tx_dis;
    // two-flop synchronisers; only the second stage is read
    d.pin_s1 = {module_reset_n, low_power_request, module_select_n,
                sda_in, scl_in};
    d.pin_s2 = q.pin_s1;
    d.pin_p = q.pin_s2[1:0];
    d.lane_s1 = lq.status;
    d.lane_s2 = q.lane_s1;
    d.lane_p = q.lane_s2;
    scl = q.pin_s2[0];
    sda = q.pin_s2[1];
    scl_rise = scl & ~q.pin_p[0];
    scl_fall = ~scl & q.pin_p[0];
    start = scl & q.pin_p[0] & q.pin_p[1] & ~sda;
    stop = scl & q.pin_p[0] & ~q.pin_p[1] & sda;
    // bus answered only once ready and while selected
    sel_ok = ~q.pin_s2[2] & q.ready;

    // microsecond tick and power-up timer
    us_tick = (q.us_cnt == US_LAST);
    d.us_cnt = us_tick ? 8'h00 : q.us_cnt + 8'h01;
    if (!q.ready && us_tick) begin
      d.init_cnt = q.init_cnt + 21'h1;
      if (q.init_cnt == INIT_LAST) begin
        d.ready = 1'b1;
        d.dnr = 1'b0;
      end
    end

    // serial slave; deselect drops the transfer and the bus
    if (stop || !sel_ok) begin
      d.st = TW_IDLE;
      d.sda_oe = 1'b0;
    end else if (start) begin
      d.st = TW_ADDR;
      d.bitn = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        TW_ADDR, TW_WR: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda};
            d.bitn = q.bitn + 4'h1;
          end else if (scl_fall && q.bitn == 4'h8) begin
            d.bitn = 4'h0;
            if (q.st == TW_ADDR) begin
              // single device address for all pages
              if (q.shift[7:1] == DEV_ADDR) begin
                d.st = TW_ADDR_ACK;
                d.sda_oe = 1'b1;
                d.is_read = q.shift[0];
                d.first = ~q.shift[0];
              end else begin
                d.st = TW_IDLE;
              end
            end else begin
              d.st = TW_WR_ACK;
              d.sda_oe = 1'b1;
              d.first = 1'b0;
              if (q.first) begin
                d.offset = q.shift;
              end else begin
                d.offset = q.offset + 8'h01;
                if (!q.offset[7]) begin
                  case (q.offset)
                    OFS_TXDIS: d.tx_dis = q.shift[3:0];
                    OFS_PWR: d.pwr_down = q.shift[PWR_DOWN_BIT];
                    OFS_MASK_LOS: d.mask_los = q.shift;
                    OFS_MASK_FAULT: d.mask_fault = q.shift[3:0];
                    OFS_PAGE: d.page = q.shift[1:0];
                    default: d.offset = q.offset + 8'h01;
                  endcase
                end else if (q.page == CTL_PAGE &&
                             q.offset == OFS_SQDIS) begin
                  d.sqdis = q.shift;
                end else if (q.page == CTL_PAGE &&
                             q.offset == OFS_RXDIS) begin
                  d.rx_dis = q.shift[7:4];
                end else begin
                  mem_we = 1'b1; // identity, thresholds
                end
              end
            end
          end
        end
        TW_ADDR_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitn = 4'h0;
            if (q.is_read) begin
              load = 1'b1;
            end else begin
              d.st = TW_WR;
            end
          end
        end
        TW_WR_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.st = TW_WR;
          end
        end
        TW_RD: begin
          if (scl_fall) begin
            if (q.bitn == 4'h8) begin
              d.sda_oe = 1'b0;
              d.st = TW_RD_ACK;
            end else begin
              d.sda_oe = ~q.shift[7];
              d.shift = {q.shift[6:0], 1'b0};
              d.bitn = q.bitn + 4'h1;
            end
          end
        end
        TW_RD_ACK: begin
          if (scl_rise) begin
            d.acked = ~sda;
          end else if (scl_fall) begin
            if (q.acked) begin
              load = 1'b1;
            end else begin
              d.st = TW_IDLE;
            end
          end
        end
        default: d.st = TW_IDLE;
      endcase
    end

    // fetch the byte at the offset and drive its first bit
    if (load) begin
      if (!q.offset[7]) begin
        byte_v = rd_lower(q, q.offset);
      end else if (is_ctl(q.page, q.offset)) begin
        byte_v = (q.offset == OFS_SQDIS) ? q.sqdis : {q.rx_dis, 4'h0};
      end else begin
        byte_v = mem_rdata;
      end
      clr2 = (q.offset == OFS_STATUS);
      clr3 = (q.offset == OFS_LOS);
      clr4 = (q.offset == OFS_FAULT);
      d.st = TW_RD;
      d.sda_oe = ~byte_v[7];
      d.shift = {byte_v[6:0], 1'b0};
      d.bitn = 4'h1;
      d.offset = q.offset + 8'h01;
    end

    // latched flags: a new event wins over a read clear
    lvl = q.lane_s2;
    rise = q.lane_s2 & ~q.lane_p;
    d.los_flag = (clr3 ? 8'h00 : q.los_flag) | rise[7:0];
    d.fault_flag = (clr4 ? 4'h0 : q.fault_flag) | rise[11:8];
    d.init_flag = (clr2 ? 1'b0 : q.init_flag) |
                  (d.ready & ~q.ready);
    // fault holds channel off until tx disable bit toggles clear
    d.fault_state = (q.fault_state &
                     ~((txdis_old ^ d.tx_dis) & ~lvl[11:8])) |
                    rise[11:8];

    // soft reset after the pin has stayed low long enough
    if (q.pin_s2[4]) begin
      d.rst_cnt = 10'h000;
      d.rst_hold = 1'b0;
    end else if (q.rst_cnt != RESET_MIN_CYCLES) begin
      d.rst_cnt = q.rst_cnt + 10'h001;
    end else begin
      d.rst_hold = 1'b1;
    end
    if (q.rst_hold) begin
      keep = d;
      d = CORE_RST;
      d.pin_s1 = keep.pin_s1;
      d.pin_s2 = keep.pin_s2;
      d.pin_p = keep.pin_p;
      d.lane_s1 = keep.lane_s1;
      d.lane_s2 = keep.lane_s2;
      d.lane_p = keep.lane_p; // never read the first sync stage
      d.rst_cnt = keep.rst_cnt;
      d.rst_hold = keep.rst_hold;
      mem_we = 1'b0;
    end

    // unmasked flags drive the pin; read clear releases it
    irq = |(d.los_flag & ~d.mask_los) |
          |(d.fault_flag & ~d.mask_fault) | d.init_flag;
    d.irq_oe = irq;
    // control levels registered before crossing to lanes
    d.ctrl = {d.ready, d.pwr_down | q.pin_s2[3], d.fault_state,
              d.sqdis[7:4], d.sqdis[3:0], d.rx_dis, d.tx_dis};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // lane domain: squelch and output enables from synced controls
  always_comb begin
    logic [3:0] txdis, rxdis, txsqd, rxsqd, fault;
    logic lp, rdy;
    ld = lq;
    ld.ctrl_s1 = q.ctrl;
    ld.ctrl_s2 = lq.ctrl_s1;
    ld.status = {tx_fault_raw, tx_los_raw, rx_los_raw};
    {rdy, lp, fault, rxsqd, txsqd, rxdis, txdis} = lq.ctrl_s2;
    // raw lane levels act directly, well inside the squelch bounds
    ld.rx_sq = rx_los_raw & ~rxsqd;
    ld.tx_sq = tx_los_raw & ~txsqd;
    ld.rx_on = ~rxdis & {4{rdy & ~lp}};
    ld.tx_on = ~txdis & ~fault & ~tx_fault_raw &
               {4{rdy & ~lp}};
  end

  always_ff @(posedge lane_clk or negedge nrst) begin
    if (!nrst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // open-drain pins only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign interrupt_n_out = 1'b0;
  assign interrupt_n_oe = q.irq_oe;
  assign rx_squelch = lq.rx_sq;
  assign tx_squelch = lq.tx_sq;
  assign rx_output_on = lq.rx_on;
  assign tx_output_on = lq.tx_on;
  assign low_power_state = q.ctrl[20];
  assign module_ready = q.ready;
endmodule // module_mgmt
`default_nettype wire

// [tb/module_mgmt_monitor.sv]
`default_nettype none
module module_mgmt_monitor
  import mgmt_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic lane_clk, // lane clock
  input wire logic module_select_n, // select pin
  input wire logic low_power_request, // low power pin
  input wire logic module_reset_n, // reset pin
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data drive enable
  input wire logic interrupt_n_out, // interrupt drive value
  input wire logic interrupt_n_oe, // interrupt drive enable
  input wire logic [LANES-1:0] rx_los_raw, // rx loss
  input wire logic [LANES-1:0] tx_los_raw, // tx loss
  input wire logic [LANES-1:0] tx_fault_raw, // tx fault
  input wire logic [LANES-1:0] rx_squelch, // rx squelch
  input wire logic [LANES-1:0] tx_squelch, // tx squelch
  input wire logic [LANES-1:0] tx_output_on, // tx output on
  input wire logic low_power_state, // power level 1
  input wire logic module_ready // fully functional
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] low_cnt_q; // cycles the reset pin has been low
  logic [LANES-1:0][3:0] fhold_q; // lane cycles of unbroken fault
  // saturating, so a long pulse never wraps back under the limit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_q <= 10'h000;
    end else if (module_reset_n) begin
      low_cnt_q <= 10'h000;
    end else if (low_cnt_q != 10'h3FF) begin
      low_cnt_q <= low_cnt_q + 10'h001;
    end
  end
  // age of each raw fault
  always_ff @(posedge lane_clk or negedge nrst) begin
    if (!nrst) begin
      fhold_q <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (!tx_fault_raw[i]) begin
          fhold_q[i] <= 4'h0;
        end else if (fhold_q[i] != 4'hF) begin
          fhold_q[i] <= fhold_q[i] + 4'h1;
        end
      end
    end
  end
  property p_ready_hold;
    @(posedge clk) disable iff (!nrst)
      module_ready && module_reset_n && $past(module_reset_n, 4)
      |=> module_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without reset");
  property p_soft_reset;
    @(posedge clk) disable iff (!nrst)
      low_cnt_q > RESET_MIN_CYCLES + 10'h008 |-> !module_ready;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("ready during long reset pulse");
  property p_deselect;
    @(posedge clk) disable iff (!nrst)
      module_select_n && $past(module_select_n, 5) |-> !sda_oe;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("data driven while deselected");
  property p_not_ready;
    @(posedge clk) disable iff (!nrst)
      !module_ready && !$past(module_ready, 4) |-> !sda_oe;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("data driven before ready");
  property p_open_drain;
    @(posedge clk) disable iff (!nrst)
      !sda_out && !interrupt_n_out &&
      (!$rose(module_ready) || interrupt_n_oe);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high or init interrupt missing");
  property p_rx_sq;
    @(posedge lane_clk) disable iff (!nrst)
      (rx_squelch & ~$past(rx_los_raw)) == 4'h0;
  endproperty
  a_rx_sq: assert property (p_rx_sq)
    else $error("rx squelch without loss");
  property p_tx_sq;
    @(posedge lane_clk) disable iff (!nrst)
      (tx_squelch & ~$past(tx_los_raw)) == 4'h0;
  endproperty
  a_tx_sq: assert property (p_tx_sq)
    else $error("tx squelch without loss");
  property p_lp_req;
    @(posedge clk) disable iff (!nrst)
      low_power_request [*4] |=> low_power_state;
  endproperty
  a_lp_req: assert property (p_lp_req)
    else $error("low power request ignored");
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    property p_tx_fault_off;
      @(posedge lane_clk) disable iff (!nrst)
        fhold_q[i] >= 4'hC |-> !tx_output_on[i];
    endproperty
    a_tx_fault_off: assert property (p_tx_fault_off)
      else $error("tx output on during fault");
  end
  c_ready: cover property (@(posedge clk) disable iff (!nrst)
    $rose(module_ready));
  c_irq: cover property (@(posedge clk) disable iff (!nrst)
    $rose(interrupt_n_oe));
  c_ack: cover property (@(posedge clk) disable iff (!nrst) $rose(sda_oe));
endmodule // module_mgmt_monitor
bind module_mgmt module_mgmt_monitor module_mgmt_monitor_i (
  .clk(clk), .nrst(nrst), .lane_clk(lane_clk),
  .module_select_n(module_select_n), .low_power_request(low_power_request),
  .module_reset_n(module_reset_n), .sda_out(sda_out), .sda_oe(sda_oe),
  .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe),
  .rx_los_raw(rx_los_raw), .tx_los_raw(tx_los_raw),
  .tx_fault_raw(tx_fault_raw), .rx_squelch(rx_squelch),
  .tx_squelch(tx_squelch), .tx_output_on(tx_output_on),
  .low_power_state(low_power_state), .module_ready(module_ready)
);
`default_nettype wire

// [tb/twi_host_model.sv]
`default_nettype none
module twi_host_model
  import mgmt_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sda_line, // resolved data line level
  output logic scl, // clock line
  output logic sda_pull // high pulls data line low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PH = 22; // phase length, above the 20 cycle minimum
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data never moves in the step where clock falls: false start hazard
  task automatic start();
    sda_pull = 1'b0;
    cyc(PH);
    scl = 1'b1;
    cyc(PH);
    sda_pull = 1'b1;
    cyc(PH);
    scl = 1'b0;
    cyc(5);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    cyc(PH);
    scl = 1'b1;
    cyc(PH);
    sda_pull = 1'b0;
    cyc(PH);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_pull = ~tx[i];
      cyc(PH);
      scl = 1'b1;
      cyc(PH);
      rx[i] = sda_line;
      scl = 1'b0;
      cyc(5);
    end
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs,
                           input logic [7:0] v, output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    xbyte({a, 1'b0, 1'b1}, r0);
    xbyte({ofs, 1'b1}, r1);
    xbyte({v, 1'b1}, r2);
    stop();
    ok = ~(r0[0] | r1[0] | r2[0]);
  endtask
  // offset write, repeated start, one byte read ended by nack
  task automatic read_reg(input logic [6:0] a, input logic [7:0] ofs,
                          output logic [7:0] v, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    start();
    xbyte({a, 1'b0, 1'b1}, r0);
    xbyte({ofs, 1'b1}, r1);
    start();
    xbyte({a, 1'b1, 1'b1}, r2);
    xbyte(9'h1FF, r3);
    stop();
    v = r3[8:1];
    ok = ~(r0[0] | r1[0] | r2[0]);
  endtask
endmodule // twi_host_model
`default_nettype wire

// [tb/test_module_mgmt.sv]
`default_nettype none
module test_module_mgmt
  import mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, lane_clk, module_select_n, low_power_request;
  logic module_reset_n, scl, host_pull, sda_in, ok;
  logic sda_out, sda_oe, interrupt_n_out, interrupt_n_oe;
  logic low_power_state, module_ready;
  logic [LANES-1:0] rx_los_raw, tx_los_raw, tx_fault_raw;
  logic [LANES-1:0] rx_squelch, tx_squelch, rx_output_on, tx_output_on;
  logic [7:0] d;
  int bad_count, checked;
  // open-drain data line with pull-up
  assign sda_in = ~(sda_oe | host_pull);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // lane clock offset so the domains never line up
  initial begin
    lane_clk = 1'b0;
    #3.3;
    forever #16 lane_clk = ~lane_clk;
  end
  module_mgmt #(.INIT_WAIT_US(2)) module_mgmt_i (
    .clk(clk), .nrst(nrst), .lane_clk(lane_clk),
    .module_select_n(module_select_n), .low_power_request(low_power_request),
    .module_reset_n(module_reset_n), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .interrupt_n_out(interrupt_n_out),
    .interrupt_n_oe(interrupt_n_oe), .rx_los_raw(rx_los_raw),
    .tx_los_raw(tx_los_raw), .tx_fault_raw(tx_fault_raw),
    .rx_squelch(rx_squelch), .tx_squelch(tx_squelch),
    .rx_output_on(rx_output_on), .tx_output_on(tx_output_on),
    .low_power_state(low_power_state), .module_ready(module_ready)
  );
  twi_host_model twi_host_model_i (
    .clk(clk), .sda_line(sda_in), .scl(scl), .sda_pull(host_pull)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    twi_host_model_i.write_reg(DEV_ADDR, ofs, v, ok);
    check(8'(ok), 8'h01);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] m, e);
    twi_host_model_i.read_reg(DEV_ADDR, ofs, d, ok);
    check(8'(ok), 8'h01);
    check(d & m, e);
  endtask
  // lane levels change on the lane clock, then settle through the sync
  task automatic lane(input logic [3:0] r, t, f);
    @(posedge lane_clk);
    #1;
    rx_los_raw = r;
    tx_los_raw = t;
    tx_fault_raw = f;
    repeat (12) @(posedge lane_clk);
    cyc(1);
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 3000 && module_ready !== 1'b1; k++) begin
      @(posedge clk);
    end
    cyc(2);
  endtask
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    module_select_n = 1'b0;
    low_power_request = 1'b0;
    module_reset_n = 1'b1;
    {rx_los_raw, tx_los_raw, tx_fault_raw} = '0;
    cyc(4);
    nrst = 1'b1;
    wait_ready();
    check(8'(module_ready), 8'h01);
    check(8'(interrupt_n_oe), 8'h01);
    rd(OFS_STATUS, 8'h03, 8'h02);
    check(8'(interrupt_n_oe), 8'h00);
    module_select_n = 1'b1;
    cyc(10);
    twi_host_model_i.write_reg(DEV_ADDR, OFS_PWR, 8'h02, ok);
    check(8'(ok), 8'h00);
    module_select_n = 1'b0;
    cyc(10);
    twi_host_model_i.write_reg(DEV_ADDR + 7'h01, OFS_PWR, 8'h02, ok);
    check(8'(ok), 8'h00);
    lane(4'h1, 4'h0, 4'h0);
    check(8'(rx_squelch), 8'h01);
    check(8'(interrupt_n_oe), 8'h01);
    rd(OFS_LOS, 8'hFF, 8'h01);
    check(8'(interrupt_n_oe), 8'h00);
    rd(OFS_LOS, 8'hFF, 8'h00);
    wr(OFS_PAGE, {6'h00, CTL_PAGE});
    wr(OFS_SQDIS, 8'h10);
    lane(4'h1, 4'h0, 4'h0);
    check(8'(rx_squelch), 8'h00);
    wr(OFS_SQDIS, 8'h00);
    lane(4'h1, 4'h0, 4'h0);
    check(8'(rx_squelch), 8'h01);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(rx_squelch), 8'h00);
    wr(OFS_RXDIS, 8'h10);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(rx_output_on[0]), 8'h00);
    rd(OFS_RXDIS, 8'hF0, 8'h10);
    wr(OFS_RXDIS, 8'h00);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(rx_output_on[0]), 8'h01);
    wr(OFS_PAGE, 8'h00);
    wr(8'h80, 8'h5A);
    rd(8'h80, 8'hFF, 8'h5A);
    rd(OFS_LOS, 8'hFF, 8'h00);
    wr(OFS_MASK_LOS, 8'h01);
    lane(4'h1, 4'h0, 4'h0);
    check(8'(interrupt_n_oe), 8'h00);
    wr(OFS_MASK_LOS, 8'h00);
    check(8'(interrupt_n_oe), 8'h01);
    rd(OFS_LOS, 8'hFF, 8'h01);
    lane(4'h0, 4'h8, 4'h2);
    check(8'(tx_squelch), 8'h08);
    check(8'(tx_output_on), 8'h0D);
    check(8'(interrupt_n_oe), 8'h01);
    rd(OFS_LOS, 8'hFF, 8'h80);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(tx_output_on), 8'h0D);
    rd(OFS_FAULT, 8'hFF, 8'h02);
    check(8'(interrupt_n_oe), 8'h00);
    wr(OFS_TXDIS, 8'h02);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(tx_output_on), 8'h0D);
    wr(OFS_TXDIS, 8'h00);
    lane(4'h0, 4'h0, 4'h0);
    check(8'(tx_output_on), 8'h0F);
    wr(OFS_PWR, 8'h02);
    check(8'(low_power_state), 8'h01);
    wr(OFS_PWR, 8'h00);
    check(8'(low_power_state), 8'h00);
    low_power_request = 1'b1;
    cyc(10);
    check(8'(low_power_state), 8'h01);
    low_power_request = 1'b0;
    module_reset_n = 1'b0;
    cyc(500); // pin held well past the shortest pulse
    check(8'(module_ready), 8'h00);
    module_reset_n = 1'b1;
    wait_ready();
    check(8'(module_ready), 8'h01);
    rd(OFS_STATUS, 8'h03, 8'h02);
    report_and_stop();
  end
endmodule // test_module_mgmt
`default_nettype wire
